// ==== hdl/afe_range_power_config_regs.sv ====
// front-end range, common-mode, power and init configuration registers
`timescale 1ns/10ps
`include "afe_cfg_map.svh"

module afe_range_power_config_regs
(
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  // register port
  input  wire logic [7:0]            regAddr,
  input  wire logic [15:0]           regWrData,
  input  wire logic                  regWrStb,
  input  wire logic                  regRdStb,
  output logic      [15:0]           regRdData,
  // channel spans
  output logic      [3:0]            input_span_first,
  output logic      [3:0]            input_span_second,
  output logic      [3:0]            input_span_third,
  output logic      [3:0]            input_span_fourth,
  output logic      [3:0]            input_span_fifth,
  output logic      [3:0]            input_span_sixth,
  output logic      [3:0]            input_span_seventh,
  output logic      [3:0]            input_span_eighth,
  output logic      [7:0]            spanCodeValid,
  // common mode
  output logic      [1:0]            common_span_group_low,
  output logic      [1:0]            common_span_group_high,
  output logic                       common_ctrl_on_group_low,
  output logic                       common_ctrl_on_group_high,
  output logic                       common_ctrl_global_on,
  output afe_cfg_pkg::common_span_t  cmSpanLow,
  output afe_cfg_pkg::common_span_t  cmSpanHigh,
  // power and initialization
  output logic                       whole_device_sleep,
  output logic                       amp_startup_one,
  output logic                       amp_startup_two,
  output logic                       coreInitDone,
  // averaging and speed-boost settings
  output logic                       averaging_setting_one,
  output logic      [1:0]            averaging_setting_two,
  output logic      [1:0]            averaging_setting_four,
  output logic      [1:0]            speedup_setting_one,
  output logic                       speedup_setting_two
);

  // ----------------------------------------
  // reset synchroniser
  // ----------------------------------------
  logic rstMeta_reg;
  logic rstSync_reg;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end
    else
    begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end

  wire logic rstSync_n;
  assign rstSync_n = rstSync_reg;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  wire logic selRangeLow;
  wire logic selRangeHigh;
  wire logic selCmPower;
  wire logic selInitBoost;
  wire logic selAny;

  assign selRangeLow  = (regAddr == `OFS_RANGE_LOW);
  assign selRangeHigh = (regAddr == `OFS_RANGE_HIGH);
  assign selCmPower   = (regAddr == `OFS_CM_POWER);
  assign selInitBoost = (regAddr == `OFS_INIT_BOOST);
  assign selAny       = selRangeLow | selRangeHigh | selCmPower | selInitBoost;

  // ----------------------------------------
  // storage: whole words kept, reserved bits included
  // ----------------------------------------
  logic [15:0] rangeLow_reg;
  logic [15:0] rangeHigh_reg;
  logic [15:0] cmPower_reg;
  logic [15:0] initBoost_reg;

  always_ff @(posedge ref_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      rangeLow_reg  <= `REG_RESET;
      rangeHigh_reg <= `REG_RESET;
      cmPower_reg   <= `REG_RESET;
      initBoost_reg <= `REG_RESET;
    end
    else if (regWrStb)
    begin
      if (selRangeLow)
        rangeLow_reg <= regWrData;
      if (selRangeHigh)
        rangeHigh_reg <= regWrData;
      if (selCmPower)
        cmPower_reg <= regWrData;
      if (selInitBoost)
        initBoost_reg <= regWrData;
    end
  end

  // ----------------------------------------
  // read path, data one cycle after the strobe
  // ----------------------------------------
  wire logic [15:0] rdMux;

  assign rdMux = selRangeLow  ? rangeLow_reg  :
                 selRangeHigh ? rangeHigh_reg :
                 selCmPower   ? cmPower_reg   :
                 selInitBoost ? initBoost_reg :
                 16'h0000;

  wire logic [15:0] regRdData_next;
  assign regRdData_next = (regRdStb && selAny) ? rdMux : 16'h0000;

  always_ff @(posedge ref_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
      regRdData <= 16'h0000;
    else
      regRdData <= regRdData_next;
  end

  // ----------------------------------------
  // decoders
  // ----------------------------------------
  wire logic [31:0]              spanAll;
  wire logic [7:0]               spanValidNext;
  afe_cfg_pkg::common_span_t     cmLowNext;
  afe_cfg_pkg::common_span_t     cmHighNext;

  assign spanAll = {rangeHigh_reg, rangeLow_reg};

  span_decode u_span_decode
  (
    .spanAll   (spanAll),
    .spanValid (spanValidNext)
  );

  cm_resolve u_cm_low
  (
    .globalOn  (initBoost_reg[`IBA_GLOBAL_BIT]),
    .groupOn   (cmPower_reg[`CMP_CMON_LO_BIT]),
    .groupSpan (cmPower_reg[`CMP_CMRNG_LO_MSB:`CMP_CMRNG_LO_LSB]),
    .cmSpan    (cmLowNext)
  );

  cm_resolve u_cm_high
  (
    .globalOn  (initBoost_reg[`IBA_GLOBAL_BIT]),
    .groupOn   (cmPower_reg[`CMP_CMON_HI_BIT]),
    .groupSpan (cmPower_reg[`CMP_CMRNG_HI_MSB:`CMP_CMRNG_HI_LSB]),
    .cmSpan    (cmHighNext)
  );

  // ----------------------------------------
  // registered field outputs, one cycle after the storage
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      input_span_first          <= 4'h0;
      input_span_second         <= 4'h0;
      input_span_third          <= 4'h0;
      input_span_fourth         <= 4'h0;
      input_span_fifth          <= 4'h0;
      input_span_sixth          <= 4'h0;
      input_span_seventh        <= 4'h0;
      input_span_eighth         <= 4'h0;
      spanCodeValid             <= 8'hFF;
      common_span_group_low     <= 2'h0;
      common_span_group_high    <= 2'h0;
      common_ctrl_on_group_low  <= 1'b0;
      common_ctrl_on_group_high <= 1'b0;
      common_ctrl_global_on     <= 1'b0;
      cmSpanLow                 <= afe_cfg_pkg::CM_TWELVE;
      cmSpanHigh                <= afe_cfg_pkg::CM_TWELVE;
      whole_device_sleep        <= 1'b0;
      amp_startup_one           <= 1'b0;
      amp_startup_two           <= 1'b0;
      coreInitDone              <= 1'b0;
      averaging_setting_one     <= 1'b0;
      averaging_setting_two     <= 2'h0;
      averaging_setting_four    <= 2'h0;
      speedup_setting_one       <= 2'h0;
      speedup_setting_two       <= 1'b0;
    end
    else
    begin
      input_span_first          <= rangeLow_reg[3:0];
      input_span_second         <= rangeLow_reg[7:4];
      input_span_third          <= rangeLow_reg[11:8];
      input_span_fourth         <= rangeLow_reg[15:12];
      input_span_fifth          <= rangeHigh_reg[3:0];
      input_span_sixth          <= rangeHigh_reg[7:4];
      input_span_seventh        <= rangeHigh_reg[11:8];
      input_span_eighth         <= rangeHigh_reg[15:12];
      spanCodeValid             <= spanValidNext;
      common_span_group_low     <= cmPower_reg[`CMP_CMRNG_LO_MSB:`CMP_CMRNG_LO_LSB];
      common_span_group_high    <= cmPower_reg[`CMP_CMRNG_HI_MSB:`CMP_CMRNG_HI_LSB];
      common_ctrl_on_group_low  <= cmPower_reg[`CMP_CMON_LO_BIT];
      common_ctrl_on_group_high <= cmPower_reg[`CMP_CMON_HI_BIT];
      common_ctrl_global_on     <= initBoost_reg[`IBA_GLOBAL_BIT];
      cmSpanLow                 <= cmLowNext;
      cmSpanHigh                <= cmHighNext;
      whole_device_sleep        <= cmPower_reg[`CMP_SLEEP_BIT];
      amp_startup_one           <= initBoost_reg[`IBA_AMP1_BIT];
      amp_startup_two           <= initBoost_reg[`IBA_AMP2_BIT];
      coreInitDone              <= initBoost_reg[`IBA_INIT3_BIT];
      averaging_setting_one     <= cmPower_reg[`CMP_AVG1_BIT];
      averaging_setting_two     <= cmPower_reg[`CMP_AVG2_MSB:`CMP_AVG2_LSB];
      averaging_setting_four    <= initBoost_reg[`IBA_AVG4_MSB:`IBA_AVG4_LSB];
      speedup_setting_one       <= initBoost_reg[`IBA_BOOST1_MSB:`IBA_BOOST1_LSB];
      speedup_setting_two       <= initBoost_reg[`IBA_BOOST2_BIT];
    end
  end

endmodule

// ==== common/afe_cfg_map.svh ====
// register offsets, field positions and codes for the front-end configuration bank
`ifndef AFE_CFG_MAP_SVH
`define AFE_CFG_MAP_SVH

// ----------------------------------------
// register indices (byte-wide address port)
// ----------------------------------------
`define OFS_RANGE_LOW     8'hC2
`define OFS_RANGE_HIGH    8'hC3
`define OFS_CM_POWER      8'hC4
`define OFS_INIT_BOOST    8'hC5

// ----------------------------------------
// reset value and widths
// ----------------------------------------
`define REG_RESET         16'h0000
`define SPAN_W            4
`define SPAN_CODE_MAX     4'h5

// ----------------------------------------
// defined (non-reserved) bits per register
// ----------------------------------------
`define CM_POWER_USED     16'h03FF
`define INIT_BOOST_USED   16'hC67C

// ----------------------------------------
// common_mode_power_control fields
// ----------------------------------------
`define CMP_SLEEP_BIT     0
`define CMP_AVG1_BIT      1
`define CMP_CMON_LO_BIT   2
`define CMP_CMON_HI_BIT   3
`define CMP_AVG2_LSB      4
`define CMP_AVG2_MSB      5
`define CMP_CMRNG_LO_LSB  6
`define CMP_CMRNG_LO_MSB  7
`define CMP_CMRNG_HI_LSB  8
`define CMP_CMRNG_HI_MSB  9

// ----------------------------------------
// init_boost_average_control fields
// ----------------------------------------
`define IBA_AMP1_BIT      2
`define IBA_BOOST2_BIT    3
`define IBA_GLOBAL_BIT    4
`define IBA_AVG4_LSB      5
`define IBA_AVG4_MSB      6
`define IBA_AMP2_BIT      9
`define IBA_INIT3_BIT     10
`define IBA_BOOST1_LSB    14
`define IBA_BOOST1_MSB    15

// ----------------------------------------
// common-mode span codes
// ----------------------------------------
`define CM_HALF_RANGE     2'h0
`define CM_SIX_VOLT       2'h1
`define CM_TWELVE_VOLT    2'h2

`endif

// ==== common/afe_cfg_pkg.sv ====
// types for the front-end configuration bank
package afe_cfg_pkg;

  // input span codes per channel
  typedef enum logic [3:0] {
    SPAN_5V0  = 4'h0,
    SPAN_3V5  = 4'h1,
    SPAN_2V5  = 4'h2,
    SPAN_7V0  = 4'h3,
    SPAN_10V0 = 4'h4,
    SPAN_12V0 = 4'h5
  } input_span_t;

  // resolved common-mode span
  typedef enum logic [1:0] {
    CM_HALF   = 2'h0,
    CM_SIX    = 2'h1,
    CM_TWELVE = 2'h2,
    CM_BAD    = 2'h3
  } common_span_t;

endpackage

// ==== hdl/span_decode.sv ====
// decodes the eight channel span fields into valid flags
`timescale 1ns/10ps
`include "afe_cfg_map.svh"

module span_decode
(
  // packed spans, channel 1 in the low nibble
  input  wire logic [31:0] spanAll,
  // one flag per channel, high when the code is defined
  output logic      [7:0]  spanValid
);

  function automatic logic codeDefined(input logic [`SPAN_W-1:0] code);
    codeDefined = (code <= `SPAN_CODE_MAX);
  endfunction

  genvar ch;
  generate
    for (ch = 0; ch < 8; ch++)
    begin : g_ch
      assign spanValid[ch] = codeDefined(spanAll[ch*`SPAN_W +: `SPAN_W]);
    end
  endgenerate

endmodule

// ==== hdl/cm_resolve.sv ====
// resolves the common-mode span of one four-channel group
`timescale 1ns/10ps
`include "afe_cfg_map.svh"

module cm_resolve
(
  // controls
  input  wire logic                        globalOn,
  input  wire logic                        groupOn,
  input  wire logic [1:0]                  groupSpan,
  // result
  output afe_cfg_pkg::common_span_t        cmSpan
);

  wire logic userDefined;
  assign userDefined = globalOn & groupOn;

  // global off or group off gives the wide twelve-volt span
  assign cmSpan = !userDefined ? afe_cfg_pkg::CM_TWELVE :
                  (groupSpan == `CM_HALF_RANGE)  ? afe_cfg_pkg::CM_HALF :
                  (groupSpan == `CM_SIX_VOLT)    ? afe_cfg_pkg::CM_SIX :
                  (groupSpan == `CM_TWELVE_VOLT) ? afe_cfg_pkg::CM_TWELVE :
                  afe_cfg_pkg::CM_BAD;

endmodule

// ==== testbench/afe_range_power_config_regs_sva.sv ====
// assertion checker for the front-end configuration register bank
`timescale 1ns/10ps
`include "afe_cfg_map.svh"

module afe_cfg_regs_chk
(
  // clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  // register port
  input  wire logic [7:0]                regAddr,
  input  wire logic [15:0]               regWrData,
  input  wire logic                      regWrStb,
  input  wire logic                      regRdStb,
  input  wire logic [15:0]               regRdData,
  // watched fields
  input  wire logic [3:0]                input_span_first,
  input  wire logic [3:0]                input_span_eighth,
  input  wire logic [7:0]                spanCodeValid,
  input  wire logic [1:0]                common_span_group_low,
  input  wire logic                      common_ctrl_on_group_low,
  input  wire logic                      common_ctrl_on_group_high,
  input  wire logic                      common_ctrl_global_on,
  input  wire afe_cfg_pkg::common_span_t cmSpanLow,
  input  wire afe_cfg_pkg::common_span_t cmSpanHigh,
  input  wire logic                      whole_device_sleep
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  rd_idle_a: assert property (!$past(regRdStb) |-> regRdData == 16'h0000)
    else $error("read data outside read cycle");
  rd_unmapped_a: assert property (regRdStb && (regAddr < `OFS_RANGE_LOW || regAddr > `OFS_INIT_BOOST)
    |=> regRdData == 16'h0000) else $error("unmapped read not zero");
  sleep_write_a: assert property (regWrStb && regAddr == `OFS_CM_POWER
    |-> ##2 whole_device_sleep == $past(regWrData[0], 2)) else $error("sleep bit not from write");
  span_low_a: assert property (regWrStb && regAddr == `OFS_RANGE_LOW
    |-> ##2 input_span_first == $past(regWrData[3:0], 2)) else $error("first span not from write");
  span_high_a: assert property (regWrStb && regAddr == `OFS_RANGE_HIGH
    |-> ##2 input_span_eighth == $past(regWrData[15:12], 2)) else $error("eighth span not from write");
  span_valid_a: assert property (spanCodeValid[0] == (input_span_first <= 4'h5)
    && spanCodeValid[7] == (input_span_eighth <= 4'h5)) else $error("span valid flag wrong");
  cm_force_a: assert property (!common_ctrl_global_on |-> cmSpanLow == afe_cfg_pkg::CM_TWELVE
    && cmSpanHigh == afe_cfg_pkg::CM_TWELVE) else $error("common mode not forced");
  cm_group_a: assert property (common_ctrl_global_on && common_ctrl_on_group_low
    |-> cmSpanLow == common_span_group_low) else $error("group span not applied");
  group_off_a: assert property (common_ctrl_global_on && !common_ctrl_on_group_high
    |-> cmSpanHigh == afe_cfg_pkg::CM_TWELVE) else $error("disabled group not forced");
endmodule

bind afe_range_power_config_regs afe_cfg_regs_chk chk_u (.ref_clk, .rst_n, .regAddr, .regWrData, .regWrStb,
  .regRdStb, .regRdData, .input_span_first, .input_span_eighth, .spanCodeValid, .common_span_group_low,
  .common_ctrl_on_group_low, .common_ctrl_on_group_high, .common_ctrl_global_on, .cmSpanLow, .cmSpanHigh,
  .whole_device_sleep);

// ==== testbench/afe_range_power_config_regs_tb.sv ====
// self-checking testbench for the front-end configuration register bank
`timescale 1ns/10ps
`include "afe_cfg_map.svh"
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("unexpected at %0t: got %h want %h", $time, got, exp); end end

module afe_range_power_config_regs_tb;
  logic                      ref_clk = 1'b0;
  logic                      rst_n = 1'b0;
  logic                      regWrStb = 1'b0;
  logic                      regRdStb = 1'b0;
  logic [7:0]                regAddr = 8'h00;
  logic [15:0]               regWrData = 16'h0000;
  logic [15:0]               regRdData;
  logic [3:0]                sp [8];
  logic [3:0]                code [8];
  logic [7:0]                spanCodeValid;
  logic [1:0]                cmLo;
  logic [1:0]                cmHi;
  logic                      enLo;
  logic                      enHi;
  logic                      glob;
  logic [11:0]               misc;
  afe_cfg_pkg::common_span_t cmSpanLow;
  afe_cfg_pkg::common_span_t cmSpanHigh;
  logic [15:0]               pat [3] = '{16'hFFFF, 16'hA5C3, 16'h0000};
  logic [15:0]               used [4] = '{16'hFFFF, 16'hFFFF, `CM_POWER_USED, `INIT_BOOST_USED};
  int                        n_fail = 0;
  int                        num_checks = 0;
  int                        cyc = 0;

  afe_range_power_config_regs dut_u (.ref_clk, .rst_n, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
    .input_span_first(sp[0]), .input_span_second(sp[1]), .input_span_third(sp[2]), .input_span_fourth(sp[3]),
    .input_span_fifth(sp[4]), .input_span_sixth(sp[5]), .input_span_seventh(sp[6]),
    .input_span_eighth(sp[7]), .spanCodeValid, .common_span_group_low(cmLo), .common_span_group_high(cmHi),
    .common_ctrl_on_group_low(enLo), .common_ctrl_on_group_high(enHi), .common_ctrl_global_on(glob),
    .cmSpanLow, .cmSpanHigh, .whole_device_sleep(misc[0]), .amp_startup_one(misc[1]),
    .amp_startup_two(misc[2]), .coreInitDone(misc[3]), .averaging_setting_one(misc[4]),
    .averaging_setting_two(misc[6:5]), .averaging_setting_four(misc[8:7]),
    .speedup_setting_one(misc[10:9]), .speedup_setting_two(misc[11]));

  always #12.5 ref_clk = ~ref_clk;

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regWrStb <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWrStb <= 1'b0;
  endtask

  // now set: strobe right at the edge that ended the previous write
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input bit now = 1'b0);
    if (!now)
      @(posedge ref_clk);
    regRdStb <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRdStb <= 1'b0;
    #1;
    `CHK(regRdData, e)
  endtask

  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      close_out();
    end
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    for (int r = 0; r < 4; r++) rd(8'(`OFS_RANGE_LOW + r), 16'h0000);
    `CHK(spanCodeValid, 8'hFF)
    `CHK(misc, 12'h000)
    `CHK(cmSpanLow, afe_cfg_pkg::CM_TWELVE)
    for (int p = 0; p < 3; p++)
    begin
      for (int r = 0; r < 4; r++) wr(8'(`OFS_RANGE_LOW + r), (pat[p] ^ 16'(r)) & used[r]);
      for (int r = 0; r < 4; r++) rd(8'(`OFS_RANGE_LOW + r), (pat[p] ^ 16'(r)) & used[r]);
    end
    for (int c = 0; c < 8; c++)
    begin
      for (int k = 0; k < 8; k++) code[k] = 4'((c + k) % 8);
      wr(`OFS_RANGE_LOW, {code[3], code[2], code[1], code[0]});
      wr(`OFS_RANGE_HIGH, {code[7], code[6], code[5], code[4]});
      settle();
      for (int k = 0; k < 8; k++)
      begin
        `CHK(sp[k], code[k])
        `CHK(spanCodeValid[k], code[k] <= 4'h5)
      end
    end
    for (int i = 0; i < 2; i++)
    begin
      wr(`OFS_CM_POWER, (16'h0259 ^ {16{i[0]}}) & `CM_POWER_USED);
      wr(`OFS_INIT_BOOST, (16'h4654 ^ {16{i[0]}}) & `INIT_BOOST_USED);
      settle();
      `CHK({cmHi, cmLo, enHi, enLo, misc[0]}, 7'h4D ^ {7{i[0]}})
      `CHK(misc, 12'h32F ^ {12{i[0]}})
      `CHK(glob, ~i[0])
    end
    for (int t = 0; t < 32; t++)
    begin
      wr(`OFS_INIT_BOOST, {11'h000, t[4], 4'h0});
      wr(`OFS_CM_POWER, {6'h00, ~t[1:0], t[1:0], 2'h0, t[3:2], 2'h0});
      settle();
      `CHK(cmSpanLow, (t[4] && t[2]) ? t[1:0] : 2'h2)
      `CHK(cmSpanHigh, (t[4] && t[3]) ? ~t[1:0] : 2'h2)
    end
    wr(8'hC6, 16'hFFFF);
    rd(8'hC6, 16'h0000);
    rd(8'hC1, 16'h0000);
    rd(`OFS_RANGE_LOW, {code[3], code[2], code[1], code[0]});
    wr(`OFS_RANGE_HIGH, 16'hBEEF);
    rd(`OFS_RANGE_HIGH, 16'hBEEF, 1'b1);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(`OFS_RANGE_HIGH, 16'h0000);
    `CHK(spanCodeValid, 8'hFF)
    `CHK(misc, 12'h000)
    close_out();
  end
endmodule
